/* File: dac_cmd_pkg.sv */
// constants and types shared by the quad dac serial command decoder
package dac_cmd_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int NUM_CHANNELS = 4;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int PD_ALL_BIT = 4;
  localparam int PD_SEL_MSB = 3;
  localparam int PD_SEL_LSB = 2;
  localparam int PD_MODE_MSB = 1;
  localparam int PD_MODE_LSB = 0;
  localparam int MIN_HOLD_BITS = 15;
  localparam logic [4:0] BIT_COUNT_RESET = 5'h00;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [1:0] GRP_DIRECT = 2'h0;
  localparam logic [1:0] GRP_INPUT = 2'h1;
  localparam logic [1:0] GRP_LOAD = 2'h2;
  localparam logic [1:0] GRP_BROAD = 2'h3;
  localparam logic [3:0] CMD_ALL_DIRECT = 4'hc;
  localparam logic [3:0] CMD_ALL_INPUT = 4'hd;
  localparam logic [3:0] CMD_ALL_LOAD = 4'he;
  localparam logic [3:0] CMD_POWER = 4'hf;
  typedef enum logic [1:0] {
    PD_WAKE,
    PD_FLOAT,
    PD_1K,
    PD_100K
  } pd_mode_t;
  localparam pd_mode_t PD_RESET = PD_100K;
  typedef enum {
    ST_IDLE,
    ST_SHIFT,
    ST_DONE
  } shift_state_t;
endpackage

/* File: dac_word_if.sv */
// carries one received serial word from the shifter to the decoder
interface dac_word_if;
  logic        valid;
  logic [15:0] word;
  modport source (output valid, output word);
  modport sink   (input  valid, input  word);
endinterface

/* File: serial_word_shifter.sv */
// serial front end: pin sync, frame tracking and 16-bit word capture
module serial_word_shifter
  import dac_cmd_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   reset_n,
  input  wire logic   serialClk,
  input  wire logic   serialData,
  input  wire logic   chipSelect_n,
  output logic        buffersOn,
  dac_word_if.source  wordOut
);
  logic [2:0] sclkSync_reg;
  logic [1:0] dinSync_reg;
  logic [2:0] csSync_reg;
  shift_state_t state_reg, state_next;
  logic [15:0] shift_reg, shift_next;
  logic [4:0]  count_reg, count_next;
  logic        valid_reg, valid_next;
  logic        sclkFall;
  logic        csFall;
  logic        csHigh;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkSync_reg <= 3'h0;
      dinSync_reg  <= 2'h0;
      csSync_reg   <= 3'h7;
    end else begin
      sclkSync_reg <= {sclkSync_reg[1:0], serialClk};
      dinSync_reg  <= {dinSync_reg[0], serialData};
      csSync_reg   <= {csSync_reg[1:0], chipSelect_n};
    end
  end

  // only stages 1 and 2 are examined; stage 0 feeds stage 1 alone
  assign sclkFall = sclkSync_reg[2] & ~sclkSync_reg[1];
  assign csFall   = csSync_reg[2] & ~csSync_reg[1];
  assign csHigh   = csSync_reg[1];

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    count_next = count_reg;
    valid_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (csFall) begin // RULE2
          state_next = ST_SHIFT;
          count_next = BIT_COUNT_RESET;
        end
      end
      ST_SHIFT: begin
        if (csHigh) begin
          // early release drops the partial word
          state_next = ST_IDLE; // RULE13
        end else if (sclkFall) begin // RULE12
          shift_next = {shift_reg[14:0], dinSync_reg[1]}; // RULE3
          count_next = 5'(count_reg + 5'h01);
          if (count_reg == 5'(WORD_BITS - 1)) begin
            valid_next = 1'b1;
            state_next = ST_DONE; // RULE1
          end
        end
      end
      ST_DONE: begin
        // buffers off: clock edges ignored until a new frame starts
        if (csFall) begin // RULE15
          state_next = ST_SHIFT;
          count_next = BIT_COUNT_RESET;
        end else if (csHigh) begin // RULE16
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      shift_reg <= 16'h0000;
      count_reg <= BIT_COUNT_RESET;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
      valid_reg <= valid_next;
    end
  end

  assign buffersOn     = (state_reg == ST_SHIFT);
  assign wordOut.valid = valid_reg;
  assign wordOut.word  = shift_reg;
endmodule

/* File: quad_dac_serial_command_decoder.sv */
// top: serial command decoder with input, dac and power-down registers

// Overview of operation
// RULE1 - after sixteen bits the clock and data buffers switch off at once
// RULE2 - chip select falling edge switches the input buffers back on
// RULE3 - word is sixteen bits msb first: command nibble, then twelve-bit code
// RULE4 - commands 0-3 write code straight to that channel's dac register
// RULE5 - commands 4-7 write code only to that channel's input register
// RULE6 - commands 8-11 copy that channel's input register to its dac
// RULE7 - command 12 writes code to all input and dac registers
// RULE8 - command 13 writes code to all four input registers only
// RULE9 - command 14 copies all input registers to dac registers together
// RULE10 - dac registers hold unsigned twelve-bit straight binary codes
// RULE11 - command 15 sets power-down mode per channel or for all
// RULE12 - data sampled on falling serial clock; word acts after sixteen bits
// RULE13 - chip select rising before the word completes discards it
// RULE14 - reset clears all registers, channels powered down with 100k load
// RULE15 - clock edges after the sixteenth bit change nothing until reselect
// RULE16 - host returns chip select high between words
module quad_dac_serial_command_decoder
  import dac_cmd_pkg::*;
#(
  parameter int CODE_WIDTH = CODE_BITS
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  serialClk,
  input  wire logic                  serialData,
  input  wire logic                  chipSelect_n,
  output logic [CODE_WIDTH-1:0]      analog_out_a,
  output logic [CODE_WIDTH-1:0]      analog_out_b,
  output logic [CODE_WIDTH-1:0]      analog_out_c,
  output logic [CODE_WIDTH-1:0]      analog_out_d,
  output logic [NUM_CHANNELS-1:0]    channelPowered,
  output logic [2*NUM_CHANNELS-1:0]  powerDownMode,
  output logic                       inputBuffersOn,
  output logic                       wordStrobe
);
  dac_word_if wordLink ();
  logic buffersOn;

  serial_word_shifter shifter (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .serialClk    (serialClk),
    .serialData   (serialData),
    .chipSelect_n (chipSelect_n),
    .buffersOn    (buffersOn),
    .wordOut      (wordLink.source)
  );

  // input registers stage codes; dac registers feed the converters
  logic [CODE_WIDTH-1:0]   inReg_reg   [NUM_CHANNELS];
  logic [CODE_WIDTH-1:0]   inReg_next  [NUM_CHANNELS];
  logic [CODE_WIDTH-1:0]   dacReg_reg  [NUM_CHANNELS];
  logic [CODE_WIDTH-1:0]   dacReg_next [NUM_CHANNELS];

  // power-down state and the awake flags derived from it
  pd_mode_t                pdMode_reg  [NUM_CHANNELS];
  pd_mode_t                pdMode_next [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0] awake_reg;
  logic [NUM_CHANNELS-1:0] awake_next;

  // status flags
  logic                    bufOn_reg;
  logic                    bufOn_next;
  logic                    strobe_reg;
  logic                    strobe_next;

  // fields of the received word
  logic [3:0]              commandNibble;
  logic [CODE_WIDTH-1:0]   converterCode;
  logic [1:0]              chan;
  logic                    pdAll;
  logic [1:0]              pdChan;
  pd_mode_t                pdModeCode;

  // decoded command kinds, at most one set per word
  logic                    cmdDirect;
  logic                    cmdInput;
  logic                    cmdLoad;
  logic                    cmdAllDirect;
  logic                    cmdAllInput;
  logic                    cmdAllLoad;
  logic                    cmdPower;

  // per-channel picks and write enables
  logic [NUM_CHANNELS-1:0] chanHit;
  logic [NUM_CHANNELS-1:0] pdHit;
  logic [NUM_CHANNELS-1:0] writeInput;
  logic [NUM_CHANNELS-1:0] writeDac;
  logic [NUM_CHANNELS-1:0] copyInput;
  logic [NUM_CHANNELS-1:0] setPower;

  assign commandNibble = wordLink.word[CMD_MSB:CMD_LSB]; // RULE3
  assign converterCode = wordLink.word[CODE_WIDTH-1:0];
  assign chan          = commandNibble[1:0];
  assign pdAll         = converterCode[PD_ALL_BIT];
  assign pdChan        = converterCode[PD_SEL_MSB:PD_SEL_LSB];
  assign pdModeCode    = pd_mode_t'(converterCode[PD_MODE_MSB:PD_MODE_LSB]);

  // every nibble has a meaning, so no word is ever refused
  always_comb begin
    cmdDirect    = 1'b0;
    cmdInput     = 1'b0;
    cmdLoad      = 1'b0;
    cmdAllDirect = 1'b0;
    cmdAllInput  = 1'b0;
    cmdAllLoad   = 1'b0;
    cmdPower     = 1'b0;
    case (commandNibble[3:2])
      GRP_DIRECT: cmdDirect = 1'b1; // RULE4
      GRP_INPUT:  cmdInput  = 1'b1; // RULE5
      GRP_LOAD:   cmdLoad   = 1'b1; // RULE6
      GRP_BROAD: begin
        // broadcast group: the whole nibble picks the kind
        case (commandNibble)
          CMD_ALL_DIRECT: cmdAllDirect = 1'b1; // RULE7
          CMD_ALL_INPUT:  cmdAllInput  = 1'b1; // RULE8
          CMD_ALL_LOAD:   cmdAllLoad   = 1'b1; // RULE9
          CMD_POWER:      cmdPower     = 1'b1; // RULE11
          default:        cmdPower     = 1'b0;
        endcase
      end
      default: cmdDirect = 1'b0;
    endcase
  end

  // one-hot channel picks for the single-channel and per-channel power commands
  always_comb begin
    chanHit = '0;
    pdHit   = '0;
    case (chan)
      2'h0:    chanHit[0] = 1'b1;
      2'h1:    chanHit[1] = 1'b1;
      2'h2:    chanHit[2] = 1'b1;
      2'h3:    chanHit[3] = 1'b1;
      default: chanHit    = '0;
    endcase
    // the all-channels bit overrides the channel field
    if (pdAll) begin // RULE11
      pdHit = '1;
    end else begin
      case (pdChan)
        2'h0:    pdHit[0] = 1'b1;
        2'h1:    pdHit[1] = 1'b1;
        2'h2:    pdHit[2] = 1'b1;
        2'h3:    pdHit[3] = 1'b1;
        default: pdHit    = '0;
      endcase
    end
  end

  always_comb begin
    writeInput = '0;
    writeDac   = '0;
    copyInput  = '0;
    setPower   = '0;
    // nothing moves until a whole word has arrived
    if (wordLink.valid) begin // RULE12
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        // a direct write passes through the input register as well
        writeInput[i] = chanHit[i] && (cmdDirect || cmdInput);
        writeDac[i]   = chanHit[i] && cmdDirect;
        copyInput[i]  = chanHit[i] && cmdLoad;
        // broadcast commands 12 to 14 reach every channel
        if (cmdAllDirect || cmdAllInput) begin
          writeInput[i] = 1'b1;
        end
        if (cmdAllDirect) begin
          writeDac[i] = 1'b1;
        end
        if (cmdAllLoad) begin
          copyInput[i] = 1'b1;
        end
        setPower[i]   = pdHit[i] && cmdPower;
      end
    end
  end

  // input registers
  always_comb begin
    inReg_next = inReg_reg;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (writeInput[i]) begin
        inReg_next[i] = converterCode; // RULE5 RULE8
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        inReg_reg[i] <= CODE_RESET; // RULE14
      end
    end else begin
      inReg_reg <= inReg_next;
    end
  end

  // dac registers
  always_comb begin
    dacReg_next = dacReg_reg;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (writeDac[i]) begin
        dacReg_next[i] = converterCode; // RULE4 RULE7
      end else if (copyInput[i]) begin
        // a load copies the staged code and ignores this word's code bits
        dacReg_next[i] = inReg_reg[i]; // RULE6 RULE9
      end
    end
  end

  // unsigned straight codes: all ones is full scale, all zeros is zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        dacReg_reg[i] <= CODE_RESET; // RULE14
      end
    end else begin
      dacReg_reg <= dacReg_next; // RULE10
    end
  end

  // power-down modes
  always_comb begin
    pdMode_next = pdMode_reg;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (setPower[i]) begin
        // codes are kept through power-down and return on wake-up
        pdMode_next[i] = pdModeCode; // RULE11
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        pdMode_reg[i] <= PD_RESET; // RULE14
      end
    end else begin
      pdMode_reg <= pdMode_next;
    end
  end

  // awake flags are registered so the port needs no decode after a flop
  always_comb begin
    awake_next = awake_reg;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      awake_next[i] = (pdMode_next[i] == PD_WAKE);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      awake_reg <= '0; // RULE14
    end else begin
      awake_reg <= awake_next;
    end
  end

  // buffer status trails the shifter by one cycle
  always_comb begin
    bufOn_next = buffersOn; // RULE1
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bufOn_reg <= 1'b0;
    end else begin
      bufOn_reg <= bufOn_next;
    end
  end

  // strobe marks the edge on which the registers took the word
  always_comb begin
    strobe_next = wordLink.valid; // RULE12
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= strobe_next;
    end
  end

  // outputs read registers directly so they never glitch on a command
  assign analog_out_a   = dacReg_reg[0];
  assign analog_out_b   = dacReg_reg[1];
  assign analog_out_c   = dacReg_reg[2];
  assign analog_out_d   = dacReg_reg[3];
  assign channelPowered = awake_reg;
  assign inputBuffersOn = bufOn_reg;
  assign wordStrobe     = strobe_reg;

  generate
    for (genvar g = 0; g < NUM_CHANNELS; g++) begin : gPd
      assign powerDownMode[2*g+1:2*g] = pdMode_reg[g];
    end
  endgenerate
endmodule

/* File: quad_dac_host_model.sv */
// host controller model for the three-wire write-only port
module quad_dac_host_model (
  input  wire logic sys_clk,
  output logic      serialClk,
  output logic      serialData,
  output logic      chipSelect_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    chipSelect_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // clock idles low; data held across each falling edge
  task automatic send(input logic [15:0] w, input int nb);
    tick(1);
    chipSelect_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      tick(6);
      serialClk = 1'b1;
      serialData = (i < 16) ? w[15-i] : 1'(i);
      tick(6);
      serialClk = 1'b0;
    end
    tick(6);
    chipSelect_n = 1'b1;
    // released line has no pull, so it shows the opposite level
    serialData = ~serialData;
    tick(24);
  endtask
endmodule

/* File: quad_dac_serial_command_decoder_assertions.sv */
// port-level checks for the quad dac serial command decoder
module quad_dac_serial_command_decoder_assertions
  import dac_cmd_pkg::*;
#(parameter int CODE_WIDTH = CODE_BITS) (
  input wire logic [CODE_WIDTH-1:0]     analog_out_a,
  input wire logic [CODE_WIDTH-1:0]     analog_out_b,
  input wire logic [CODE_WIDTH-1:0]     analog_out_c,
  input wire logic [CODE_WIDTH-1:0]     analog_out_d,
  input wire logic [NUM_CHANNELS-1:0]   channelPowered,
  input wire logic [2*NUM_CHANNELS-1:0] powerDownMode,
  input wire logic                      sys_clk,
  input wire logic                      reset_n,
  input wire logic                      chipSelect_n,
  input wire logic                      inputBuffersOn,
  input wire logic                      wordStrobe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_quiet; !wordStrobe [*8]; endsequence
  property p_reset; $rose(reset_n) |-> powerDownMode == 8'hff &&
    channelPowered == 4'h0 && {analog_out_a, analog_out_b,
    analog_out_c, analog_out_d} == '0; endproperty
  property p_awake; channelPowered == {powerDownMode[7:6] == 2'h0,
    powerDownMode[5:4] == 2'h0, powerDownMode[3:2] == 2'h0,
    powerDownMode[1:0] == 2'h0}; endproperty
  property p_hold; !wordStrobe |-> $stable({analog_out_a, analog_out_b,
    analog_out_c, analog_out_d, powerDownMode}); endproperty
  property p_off; wordStrobe |-> !inputBuffersOn; endproperty
  property p_on; $fell(chipSelect_n) |-> ##[1:6] inputBuffersOn; endproperty
  property p_once; wordStrobe |=> s_quiet; endproperty
  property p_drop; $rose(chipSelect_n) && inputBuffersOn |=> s_quiet;
  endproperty
  property p_armed; $rose(inputBuffersOn) |-> !chipSelect_n; endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  a_awake: assert property (p_awake) else $error("awake flags");
  a_hold: assert property (p_hold) else $error("idle change");
  a_off: assert property (p_off) else $error("buffers on");
  a_on: assert property (p_on) else $error("buffers off");
  a_once: assert property (p_once) else $error("extra word");
  a_drop: assert property (p_drop) else $error("partial word");
  a_armed: assert property (p_armed) else $error("no select");
endmodule
bind quad_dac_serial_command_decoder
  quad_dac_serial_command_decoder_assertions #(.CODE_WIDTH(CODE_WIDTH)) chk (
    .analog_out_a(analog_out_a), .analog_out_b(analog_out_b),
    .analog_out_c(analog_out_c), .analog_out_d(analog_out_d),
    .channelPowered(channelPowered), .powerDownMode(powerDownMode),
    .sys_clk(sys_clk), .reset_n(reset_n), .chipSelect_n(chipSelect_n),
    .inputBuffersOn(inputBuffersOn), .wordStrobe(wordStrobe));

/* File: quad_dac_serial_command_decoder_tb.sv */
// self-checking bench for the quad dac serial command decoder
module quad_dac_serial_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        reset_n;
  logic        serialClk;
  logic        serialData;
  logic        chipSelect_n;
  logic        inputBuffersOn;
  logic        wordStrobe;
  logic [3:0]  channelPowered;
  logic [7:0]  powerDownMode;
  logic [11:0] out [4];
  logic [11:0] expIn [4];
  logic [11:0] expDac [4];
  logic [1:0]  expPd [4];
  int          failures = 0;
  int          comparisons = 0;
  int          strobes = 0;
  int          want;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) if (wordStrobe === 1'b1) strobes++;
  quad_dac_host_model host (.sys_clk(sys_clk), .serialClk(serialClk),
    .serialData(serialData), .chipSelect_n(chipSelect_n));
  quad_dac_serial_command_decoder dut (.sys_clk(sys_clk),
    .reset_n(reset_n), .serialClk(serialClk), .serialData(serialData),
    .chipSelect_n(chipSelect_n), .analog_out_a(out[0]),
    .analog_out_b(out[1]), .analog_out_c(out[2]), .analog_out_d(out[3]),
    .channelPowered(channelPowered), .powerDownMode(powerDownMode),
    .inputBuffersOn(inputBuffersOn), .wordStrobe(wordStrobe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // group from the nibble: 0 direct, 1 input, 2 load, 3 power
  function automatic void apply(logic [15:0] w);
    logic [1:0] g;
    g = (w[15:14] == 2'h3) ? w[13:12] : w[15:14];
    for (int i = 0; i < 4; i++) begin
      if (w[15:14] == 2'h3 ? (g != 2'h3 || w[4] || w[3:2] == 2'(i))
                           : w[13:12] == 2'(i))
        case (g)
          2'h0: {expIn[i], expDac[i]} = {w[11:0], w[11:0]};
          2'h1: expIn[i] = w[11:0];
          2'h2: expDac[i] = expIn[i];
          default: expPd[i] = w[1:0];
        endcase
    end
  endfunction
  task automatic check_all;
    for (int i = 0; i < 4; i++) begin
      chk(16'(out[i]), 16'(expDac[i]));
      chk(16'(powerDownMode[2*i+:2]), 16'(expPd[i]));
      chk(16'(channelPowered[i]), 16'(expPd[i] == 2'h0));
    end
    chk(16'(inputBuffersOn), 16'h0000);
  endtask
  task automatic do_reset;
    reset_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      {expIn[i], expDac[i], expPd[i]} = {24'h000000, 2'h3};
    end
  endtask
  // short frames are dropped; bits past sixteen must be ignored
  task automatic word(input logic [15:0] w, input int nb);
    want = strobes + 32'(nb >= 16);
    host.send(w, nb);
    if (nb >= 16)
      apply(w);
    for (int i = 0; i < 20 && strobes != want; i++) @(posedge sys_clk);
    chk(16'(strobes), 16'(want));
    check_all();
  endtask
  initial begin
    reset_n = 1'b0;
    void'($urandom(66119));
    do_reset();
    check_all();
    word(16'h4abc, 16);
    word(16'hf010, 16);
    word(16'h0fff, 16);
    word(16'h8000, 16);
    word(16'hd123, 15);
    word(16'he000, 20);
    for (int c = 0; c < 16; c++) word({4'(c), 12'($urandom)}, 16);
    for (int i = 0; i < 30; i++) word(16'($urandom), 14 + i % 7);
    do_reset();
    check_all();
    end_sim();
  end
endmodule
